// file: dv/osc_model.sv
// Oscillator and PLL model standing on the far side of the selector
`timescale 1ns/1ps
`default_nettype none

module osc_model #(
	parameter realtime HALF_NS = 10.3
) (
	input wire logic run,
	input wire logic lock_req,
	output logic osc_pulse_in,
	output logic pll_lock_in
);
	// ****************************************
	// Crystal: free of the system clock phase
	// ****************************************
	// A stopped crystal rests low, so no stray edges reach the counter
	initial
	begin
		osc_pulse_in = 1'b0;
		forever
		begin
			#(HALF_NS);
			osc_pulse_in = run ? ~osc_pulse_in : 1'b0;
		end
	end

	// Lock follows the request after an analog settling lag
	initial
	begin
		pll_lock_in = 1'b0;
		forever
		begin
			@(lock_req);
			pll_lock_in <= #7 lock_req;
		end
	end
endmodule : osc_model

`default_nettype wire

// file: dv/test_oscillator_source_select.sv
// Self-checking bench for the oscillator source selector
`timescale 1ns/1ps
`default_nettype none

module test_oscillator_source_select;
	logic sys_clk, rst_n, por_bor_event, sleep_wake, switch_go;
	logic [1:0] osc_group_config;
	logic [3:0] primary_mode_config;
	logic osc_pulse_in, pll_lock_in, osc_run, lock_req;
	logic psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [1:0] current_group_status, pll_mult;
	logic secondary_osc_run, secondary_is_clock, sys_clk_release;
	logic clock_out_function, pin2_out, pin2_oe_n, er;
	int err_total, checked;

	oscillator_source_select u_dut (.sys_clk(sys_clk), .rst_n(rst_n),
		.por_bor_event(por_bor_event), .sleep_wake(sleep_wake),
		.switch_go(switch_go), .osc_group_config(osc_group_config),
		.primary_mode_config(primary_mode_config),
		.osc_pulse_in(osc_pulse_in), .pll_lock_in(pll_lock_in),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .current_group_status(current_group_status),
		.pll_mult(pll_mult), .secondary_osc_run(secondary_osc_run),
		.secondary_is_clock(secondary_is_clock),
		.sys_clk_release(sys_clk_release),
		.clock_out_function(clock_out_function), .pin2_out(pin2_out),
		.pin2_oe_n(pin2_oe_n));
	osc_model u_osc (.run(osc_run), .lock_req(lock_req),
		.osc_pulse_in(osc_pulse_in), .pll_lock_in(pll_lock_in));

	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic chk(input string nm, input logic [31:0] seen,
		input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			err_total++;
			$display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask : chk

	task automatic report_and_stop;
		$display("errors %0d checks %0d", err_total, checked);
		if (err_total == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : report_and_stop

	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge sys_clk);
		psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do
		begin
			@(posedge sys_clk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0; penable <= 1'b0;
		if (n >= 20)
			chk("pready timeout", 0, 1);
	endtask : apb

	// Pulse one restart input for one cycle, then let it settle
	task automatic pulse(input int which, input int settle);
		@(posedge sys_clk);
		case (which)
			0: por_bor_event <= 1'b1;
			1: sleep_wake <= 1'b1;
			default: switch_go <= 1'b1;
		endcase
		@(posedge sys_clk);
		por_bor_event <= 1'b0; sleep_wake <= 1'b0; switch_go <= 1'b0;
		repeat (settle) @(posedge sys_clk);
	endtask : pulse

	task automatic wait_release;
		int n;
		for (n = 0; n < 6000 && sys_clk_release !== 1'b1; n++)
			@(posedge sys_clk);
		chk("release came", sys_clk_release, 1);
	endtask : wait_release

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_reset_load;
		apb(1'b0, osc_select_pkg::CTRL_ADDR, 32'h0);
		chk("cur group", rd[osc_select_pkg::CUR_GROUP_LSB +: 2], 2'h3);
		chk("req group", rd[osc_select_pkg::REQ_GROUP_LSB +: 2], 2'h3);
		chk("group out", current_group_status, 2'h3);
		apb(1'b0, osc_select_pkg::CFG_ADDR, 32'h0);
		chk("cfg read", rd, 32'h0B000003);
	endtask : t_reset_load

	// Every primary code: PLL gain, second pin use and start-up need
	task automatic t_modes;
		logic [3:0] m [16] = '{4'hB, 4'hC, 4'hD, 4'hE, 4'hF, 4'h9, 4'h8,
			4'h4, 4'h5, 4'h6, 4'h7, 4'h0, 4'h2, 4'h1, 4'hA, 4'h3};
		logic [1:0] p [16] = '{2'h0, 2'h0, 2'h1, 2'h2, 2'h3, 2'h0, 2'h0, 2'h0,
			2'h1, 2'h2, 2'h3, 2'h0, 2'h0, 2'h1, 2'h2, 2'h3};
		logic x;
		logic k;
		logic prev_fn;
		logic prev_pin;
		int rises_fn;
		int rises_pin;
		for (int i = 0; i < 16; i++)
		begin
			primary_mode_config <= m[i];
			pulse(0, 5);
			x = m[i] inside {4'h0, 4'h2, 4'h4, 4'h5, 4'h6, 4'h7};
			k = m[i] inside {4'hB, 4'h9};
			chk("pll mult", pll_mult, p[i]);
			chk("pin drive", pin2_oe_n, !k);
			chk("release", sys_clk_release, !x);
			// A quarter-rate square wave rises at least twice in 40 cycles
			rises_fn = 0;
			rises_pin = 0;
			prev_fn = clock_out_function;
			prev_pin = pin2_out;
			repeat (40)
			begin
				@(posedge sys_clk);
				rises_fn += int'(clock_out_function && !prev_fn);
				rises_pin += int'(pin2_out && !prev_pin);
				prev_fn = clock_out_function;
				prev_pin = pin2_out;
			end
			chk("clock out rises", rises_fn >= 2, k);
			chk("pin out rises", rises_pin >= 2, k);
		end
	endtask : t_modes

	// Crystal start-up: count restarts on wake, then 1024 periods
	task automatic t_startup;
		primary_mode_config <= osc_select_pkg::PM_HS_XTAL;
		pulse(0, 0);
		repeat (600) @(posedge osc_pulse_in);
		pulse(1, 0);
		repeat (1020) @(posedge osc_pulse_in);
		@(posedge sys_clk);
		chk("held", sys_clk_release, 0);
		apb(1'b0, osc_select_pkg::CTRL_ADDR, 32'h0);
		chk("counting bit", rd[osc_select_pkg::STARTUP_BIT], 1);
		repeat (8) @(posedge osc_pulse_in);
		repeat (3) @(posedge sys_clk);
		chk("released", sys_clk_release, 1);
	endtask : t_startup

	task automatic t_regs;
		apb(1'b1, osc_select_pkg::CFG_ADDR, 32'hFFFFFFFF);
		chk("cfg write err", er, 1);
		apb(1'b0, 8'h08, 32'h0);
		chk("unmapped err", er, 1);
		chk("unmapped data", rd, 0);
		lock_req <= 1'b1;
		// The write tries to force the read-only group field to 01
		apb(1'b1, osc_select_pkg::CTRL_ADDR, 32'h00001300);
		apb(1'b0, osc_select_pkg::CTRL_ADDR, 32'h0);
		chk("lock set", rd[osc_select_pkg::LOCK_BIT], 1);
		chk("status ro", rd[osc_select_pkg::CUR_GROUP_LSB +: 2], 2'h3);
		lock_req <= 1'b0;
		repeat (6) @(posedge sys_clk);
		apb(1'b0, osc_select_pkg::CTRL_ADDR, 32'h0);
		chk("lock lost", rd[osc_select_pkg::LOCK_BIT], 0);
	endtask : t_regs

	// Secondary group and the return to the crystal
	task automatic t_secondary;
		apb(1'b1, osc_select_pkg::CTRL_ADDR, 32'h00000000);
		pulse(2, 4);
		chk("no sec clk", secondary_is_clock, 0);
		apb(1'b1, osc_select_pkg::CTRL_ADDR, 32'h00000002);
		// The run flag follows the enable bit one cycle later
		@(posedge sys_clk);
		chk("sec run", secondary_osc_run, 1);
		pulse(2, 4);
		chk("sec group", current_group_status, 2'h0);
		chk("sec clock", secondary_is_clock, 1);
		wait_release();
		apb(1'b1, osc_select_pkg::CTRL_ADDR, 32'h00000302);
		pulse(2, 4);
		chk("back held", sys_clk_release, 0);
		chk("sec left", secondary_is_clock, 0);
		wait_release();
		// Internal RC groups need no start-up count and no multiplier
		apb(1'b1, osc_select_pkg::CTRL_ADDR, 32'h00000100);
		pulse(2, 4);
		chk("fast rc group", current_group_status, 2'h1);
		chk("fast rc release", sys_clk_release, 1);
		chk("fast rc pll", pll_mult, 2'h0);
		apb(1'b1, osc_select_pkg::CTRL_ADDR, 32'h00000200);
		pulse(2, 4);
		chk("slow rc group", current_group_status, 2'h2);
		chk("slow rc release", sys_clk_release, 1);
	endtask : t_secondary

	// ****************************************
	// Clock, reset, sequence and watchdog
	// ****************************************
	initial
	begin
		sys_clk = 1'b0;
		forever
			#2.5 sys_clk = ~sys_clk;
	end

	initial
	begin
		repeat (60000) @(posedge sys_clk);
		err_total++;
		report_and_stop();
	end

	initial
	begin
		err_total = 0; checked = 0;
		rst_n = 1'b0; por_bor_event = 1'b0; sleep_wake = 1'b0;
		switch_go = 1'b0; osc_group_config = 2'h3;
		primary_mode_config = osc_select_pkg::PM_EXT_CLK;
		osc_run = 1'b1; lock_req = 1'b0;
		psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
		paddr = 8'h00; pwdata = 32'h0;
		repeat (6) @(posedge sys_clk);
		rst_n <= 1'b1;
		t_reset_load();
		t_modes();
		t_startup();
		t_regs();
		t_secondary();
		report_and_stop();
	end
endmodule : test_oscillator_source_select

`default_nettype wire

// file: verilog/osc_select_pkg.sv
// Package: register map, field layout, encodings and timing for oscillator select
package osc_select_pkg;

	// ****************************************
	// Register map (byte addresses)
	// ****************************************
	localparam logic [7:0] CTRL_ADDR = 8'h00;
	localparam logic [7:0] CFG_ADDR = 8'h04;

	// ****************************************
	// Clock control and configuration register fields
	// ****************************************
	localparam int CUR_GROUP_LSB = 12;
	localparam int REQ_GROUP_LSB = 8;
	localparam int LOCK_BIT = 5;
	localparam int READY_BIT = 4;
	localparam int STARTUP_BIT = 3;
	localparam int SEC_EN_BIT = 1;
	localparam int PIN_FN_LSB = 16;
	localparam int PLL_MULT_LSB = 20;
	localparam int PRI_MODE_LSB = 24;

	// ****************************************
	// Encodings
	// ****************************************
	localparam logic [1:0] GRP_SECONDARY = 2'h0;
	localparam logic [1:0] GRP_FAST_RC = 2'h1;
	localparam logic [1:0] GRP_SLOW_RC = 2'h2;
	localparam logic [1:0] GRP_PRIMARY = 2'h3;

	localparam logic [3:0] PM_EXT_CLK = 4'hB;
	localparam logic [3:0] PM_EXT_CLK_IO = 4'hC;
	localparam logic [3:0] PM_EXT_CLK_PLL4 = 4'hD;
	localparam logic [3:0] PM_EXT_CLK_PLL8 = 4'hE;
	localparam logic [3:0] PM_EXT_CLK_PLL16 = 4'hF;
	localparam logic [3:0] PM_EXT_RC = 4'h9;
	localparam logic [3:0] PM_EXT_RC_IO = 4'h8;
	localparam logic [3:0] PM_MED_XTAL = 4'h4;
	localparam logic [3:0] PM_MED_XTAL_PLL4 = 4'h5;
	localparam logic [3:0] PM_MED_XTAL_PLL8 = 4'h6;
	localparam logic [3:0] PM_MED_XTAL_PLL16 = 4'h7;
	localparam logic [3:0] PM_LOW_XTAL = 4'h0;
	localparam logic [3:0] PM_HS_XTAL = 4'h2;
	localparam logic [3:0] PM_FRC_PLL4 = 4'h1;
	localparam logic [3:0] PM_FRC_PLL8 = 4'hA;
	localparam logic [3:0] PM_FRC_PLL16 = 4'h3;

	localparam logic [1:0] PLL_OFF = 2'h0;
	localparam logic [1:0] PLL_X4 = 2'h1;
	localparam logic [1:0] PLL_X8 = 2'h2;
	localparam logic [1:0] PLL_X16 = 2'h3;

	localparam logic [1:0] PIN_CRYSTAL = 2'h0;
	localparam logic [1:0] PIN_CLK_OUT = 2'h1;
	localparam logic [1:0] PIN_GPIO = 2'h2;

	// ****************************************
	// Timing
	// ****************************************
	localparam int STARTUP_WIDTH = 10;
	localparam int STARTUP_PERIODS = 1024;
	localparam int CLK_OUT_DIV = 4;

	// Decoded choice for the active source
	typedef struct packed {
		logic [1:0] pll_mult;
		logic [1:0] pin_fn;
		logic needs_startup;
		logic use_fast_rc;
	} source_info_t;

	// Stored clock-control fields
	typedef struct packed {
		logic [1:0] cur_group;
		logic [1:0] req_group;
		logic sec_en;
	} ctrl_fields_t;

endpackage : osc_select_pkg

// file: verilog/oscillator_source_select.sv
// Module: oscillator source selection, start-up gating and clock control register
// Operation
// - Reset takes the clock source from configuration; software may change it later.
// - Two-bit group field picks group; four-bit field picks primary mode.
// - Group 11 primary, 00 secondary crystal, 01 fast RC, 10 slow RC.
// - Primary mode codes map to clock, RC, crystal and PLL choices.
// - Second pin: clock/4 output, general I/O, or crystal pin by mode.
// - Ten-bit start-up counter counts 1024 oscillator periods before release.
// - Start-up delay applies on power-on, brown-out reset and Sleep wake-up.
// - Only crystal modes wait for start-up; others release at once.
// - Secondary oscillator enable keeps the 32 kHz oscillator running, even asleep.
// - Secondary oscillator clocks the device only with group 00 and enable set.
// - Returning from secondary to main oscillator still waits its start-up delay.
// - PLL multiplies primary or fast RC clock by four, eight or sixteen.
// - PLL lock status tracks lock and shows as a read-only bit.
// - Clock control register holds switching controls and clock status bits.
// - Reset loads current and requested group from the group configuration.
// - Current group status is read-only and shows the group in effect.
//
// Chosen here: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`default_nettype none

module oscillator_source_select (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic por_bor_event,
	input wire logic sleep_wake,
	input wire logic switch_go,
	input wire logic [1:0] osc_group_config,
	input wire logic [3:0] primary_mode_config,
	input wire logic osc_pulse_in,
	input wire logic pll_lock_in,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic [1:0] current_group_status,
	output logic [1:0] pll_mult,
	output logic secondary_osc_run,
	output logic secondary_is_clock,
	output logic sys_clk_release,
	output logic clock_out_function,
	output logic pin2_out,
	output logic pin2_oe_n
);

	default clocking cb_main @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);

	// ****************************************
	// Source decode
	// ****************************************
	function automatic osc_select_pkg::source_info_t decode_source(
		input logic [1:0] grp,
		input logic [3:0] mode
	);
		osc_select_pkg::source_info_t info;
		info = '0;
		info.pin_fn = osc_select_pkg::PIN_GPIO;
		if (grp == osc_select_pkg::GRP_PRIMARY)
		begin
			case (mode)
				osc_select_pkg::PM_EXT_CLK, osc_select_pkg::PM_EXT_RC:
					info.pin_fn = osc_select_pkg::PIN_CLK_OUT;
				osc_select_pkg::PM_EXT_CLK_IO, osc_select_pkg::PM_EXT_RC_IO:
					info.pin_fn = osc_select_pkg::PIN_GPIO;
				osc_select_pkg::PM_EXT_CLK_PLL4:
					info.pll_mult = osc_select_pkg::PLL_X4;
				osc_select_pkg::PM_EXT_CLK_PLL8:
					info.pll_mult = osc_select_pkg::PLL_X8;
				osc_select_pkg::PM_EXT_CLK_PLL16:
					info.pll_mult = osc_select_pkg::PLL_X16;
				osc_select_pkg::PM_MED_XTAL, osc_select_pkg::PM_LOW_XTAL,
				osc_select_pkg::PM_HS_XTAL:
				begin
					info.pin_fn = osc_select_pkg::PIN_CRYSTAL;
					info.needs_startup = 1'b1;
				end
				osc_select_pkg::PM_MED_XTAL_PLL4:
				begin
					info.pin_fn = osc_select_pkg::PIN_CRYSTAL;
					info.needs_startup = 1'b1;
					info.pll_mult = osc_select_pkg::PLL_X4;
				end
				osc_select_pkg::PM_MED_XTAL_PLL8:
				begin
					info.pin_fn = osc_select_pkg::PIN_CRYSTAL;
					info.needs_startup = 1'b1;
					info.pll_mult = osc_select_pkg::PLL_X8;
				end
				osc_select_pkg::PM_MED_XTAL_PLL16:
				begin
					info.pin_fn = osc_select_pkg::PIN_CRYSTAL;
					info.needs_startup = 1'b1;
					info.pll_mult = osc_select_pkg::PLL_X16;
				end
				osc_select_pkg::PM_FRC_PLL4:
				begin
					info.use_fast_rc = 1'b1;
					info.pll_mult = osc_select_pkg::PLL_X4;
				end
				osc_select_pkg::PM_FRC_PLL8:
				begin
					info.use_fast_rc = 1'b1;
					info.pll_mult = osc_select_pkg::PLL_X8;
				end
				osc_select_pkg::PM_FRC_PLL16:
				begin
					info.use_fast_rc = 1'b1;
					info.pll_mult = osc_select_pkg::PLL_X16;
				end
				default:
					info.pin_fn = osc_select_pkg::PIN_GPIO;
			endcase
		end
		else if (grp == osc_select_pkg::GRP_SECONDARY)
			info.needs_startup = 1'b1;
		else if (grp == osc_select_pkg::GRP_FAST_RC)
			info.use_fast_rc = 1'b1;
		return info;
	endfunction : decode_source

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		osc_select_pkg::ctrl_fields_t ctrl;
		logic [2:0] lock_sync;
		logic [2:0] osc_sync;
		logic osc_level;
		logic lock_stat;
		logic first;
		logic restart;
		logic [1:0] div_cnt;
		logic clk_out;
		logic [31:0] rdata;
		logic ready;
		logic err;
		logic [1:0] pll;
		logic [1:0] pin_fn;
		logic sec_run;
		logic sec_clk;
		logic rel;
		logic oe_n;
	} top_state_t;

	top_state_t state;
	top_state_t next_state;
	osc_select_pkg::source_info_t info;
	logic tick;
	logic running;
	logic released;
	logic access;

	assign access = psel && penable && !state.ready;
	// A rise counts once the second and third stages agree on it
	assign tick = state.osc_sync[1] && state.osc_sync[2] && !state.osc_level;

	always_comb
	begin
		next_state = state;
		info = decode_source(state.ctrl.cur_group, primary_mode_config);
		next_state.osc_sync = {state.osc_sync[1:0], osc_pulse_in};
		next_state.lock_sync = {state.lock_sync[1:0], pll_lock_in};
		// One-cycle glitches on the pins never reach the filtered levels
		if (state.osc_sync[1] == state.osc_sync[2])
			next_state.osc_level = state.osc_sync[2];
		if (state.lock_sync[1] == state.lock_sync[2])
			next_state.lock_stat = state.lock_sync[2];
		next_state.restart = 1'b0;
		next_state.first = 1'b0;
		next_state.ready = 1'b0;
		next_state.err = 1'b0;
		if (state.first || por_bor_event)
		begin
			// Configuration captured after reset release, not under reset
			next_state.ctrl.cur_group = osc_group_config;
			next_state.ctrl.req_group = osc_group_config;
			next_state.restart = 1'b1;
		end
		else if (sleep_wake)
			next_state.restart = 1'b1;
		else if (switch_go && state.ctrl.req_group != state.ctrl.cur_group)
		begin
			next_state.ctrl.cur_group = state.ctrl.req_group;
			next_state.restart = 1'b1;
		end
		if (access)
		begin
			next_state.ready = 1'b1;
			if (paddr == osc_select_pkg::CTRL_ADDR)
			begin
				if (pwrite)
				begin
					next_state.ctrl.req_group =
						pwdata[osc_select_pkg::REQ_GROUP_LSB +: 2];
					next_state.ctrl.sec_en = pwdata[osc_select_pkg::SEC_EN_BIT];
				end
				next_state.rdata = '0;
				next_state.rdata[osc_select_pkg::CUR_GROUP_LSB +: 2] =
					state.ctrl.cur_group;
				next_state.rdata[osc_select_pkg::REQ_GROUP_LSB +: 2] =
					state.ctrl.req_group;
				next_state.rdata[osc_select_pkg::LOCK_BIT] = state.lock_stat;
				next_state.rdata[osc_select_pkg::READY_BIT] = released;
				next_state.rdata[osc_select_pkg::STARTUP_BIT] = running;
				next_state.rdata[osc_select_pkg::SEC_EN_BIT] = state.ctrl.sec_en;
				next_state.rdata[osc_select_pkg::PIN_FN_LSB +: 2] = state.pin_fn;
				next_state.rdata[osc_select_pkg::PLL_MULT_LSB +: 2] = state.pll;
			end
			else if (paddr == osc_select_pkg::CFG_ADDR)
			begin
				next_state.rdata = '0;
				next_state.rdata[1:0] = osc_group_config;
				next_state.rdata[osc_select_pkg::PRI_MODE_LSB +: 4] =
					primary_mode_config;
				next_state.err = pwrite;
			end
			else
			begin
				next_state.rdata = '0;
				next_state.err = 1'b1;
			end
		end
		// Divide-by-four clock out only when the pin carries it
		if (tick)
			next_state.div_cnt = state.div_cnt + 2'h1;
		next_state.clk_out = (info.pin_fn == osc_select_pkg::PIN_CLK_OUT)
			&& state.div_cnt[1];
		next_state.pll = info.pll_mult;
		next_state.pin_fn = info.pin_fn;
		next_state.oe_n = info.pin_fn != osc_select_pkg::PIN_CLK_OUT;
		next_state.sec_run = state.ctrl.sec_en;
		next_state.sec_clk = state.ctrl.sec_en &&
			state.ctrl.cur_group == osc_select_pkg::GRP_SECONDARY;
		next_state.rel = released && !next_state.restart && !state.restart;
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			state <= '0;
			state.first <= 1'b1;
			state.oe_n <= 1'b1;
		end
		else
			state <= next_state;
	end

	startup_timer #(
		.WIDTH(osc_select_pkg::STARTUP_WIDTH)
	) u_startup (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.restart(state.restart),
		.needs_count(info.needs_startup),
		.osc_tick(tick),
		.running(running),
		.released(released)
	);

	assign prdata = state.rdata;
	assign pready = state.ready;
	assign pslverr = state.err;
	assign current_group_status = state.ctrl.cur_group;
	assign pll_mult = state.pll;
	assign secondary_osc_run = state.sec_run;
	assign secondary_is_clock = state.sec_clk;
	assign sys_clk_release = state.rel;
	assign clock_out_function = state.clk_out;
	assign pin2_out = state.clk_out;
	assign pin2_oe_n = state.oe_n;

	// ****************************************
	// Checks
	// ****************************************
	a_gated_running: assert property (
		running |-> !sys_clk_release)
		else $error("clock released while start-up counting");
	a_sec_clock_cond: assert property (
		secondary_is_clock |-> $past(state.ctrl.sec_en))
		else $error("secondary clock without enable");
	a_sec_run_enable: assert property (
		$rose(state.ctrl.sec_en) |=> secondary_osc_run)
		else $error("secondary oscillator not running");
	a_restart_gates: assert property (
		state.restart |=> !sys_clk_release)
		else $error("clock not gated on restart");
	a_nocount_release: assert property (
		state.restart && !info.needs_startup
		|-> ##2 (sys_clk_release || $past(state.restart)))
		else $error("non-crystal mode delayed");
	a_lock_follow: assert property (
		pll_lock_in [*5] |-> state.lock_stat)
		else $error("lock status not following");
	a_lock_drop: assert property (
		!pll_lock_in [*5] |-> !state.lock_stat)
		else $error("lock status not dropping");
	a_reset_group: assert property (
		state.first |=> current_group_status == $past(osc_group_config))
		else $error("group not loaded at reset");
	a_pll_x16_map: assert property (
		(current_group_status == osc_select_pkg::GRP_PRIMARY &&
		primary_mode_config == osc_select_pkg::PM_FRC_PLL16) [*2]
		|-> pll_mult == osc_select_pkg::PLL_X16)
		else $error("pll gain mapping wrong");
	a_pin_quiet: assert property (
		pin2_oe_n |-> !pin2_out)
		else $error("second pin toggles while not driven");
	c_crystal_release: cover property (
		running ##1 !running ##1 sys_clk_release);
	c_switch_group: cover property (
		switch_go && state.ctrl.req_group != state.ctrl.cur_group);
	c_sec_clock: cover property (
		secondary_is_clock);

endmodule : oscillator_source_select

`default_nettype wire

// file: verilog/startup_timer.sv
// Module: oscillator start-up counter gating the released clock
`timescale 1ns/1ps
`default_nettype none

module startup_timer #(
	parameter int WIDTH = osc_select_pkg::STARTUP_WIDTH
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic restart,
	input wire logic needs_count,
	input wire logic osc_tick,
	output logic running,
	output logic released
);

	typedef struct packed {
		logic [WIDTH-1:0] count;
		logic running;
		logic released;
	} timer_state_t;

	timer_state_t state;
	timer_state_t next_state;

	always_comb
	begin
		next_state = state;
		if (restart)
		begin
			// Each restart begins again from zero; the clock is gated only when a count is needed
			next_state.count = '0;
			next_state.running = needs_count;
			next_state.released = !needs_count;
		end
		else if (state.running && osc_tick)
		begin
			next_state.count = state.count + 1'b1;
			if (&state.count)
			begin
				next_state.running = 1'b0;
				next_state.released = 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
			state <= '0;
		else
			state <= next_state;
	end

	assign running = state.running;
	assign released = state.released;

endmodule : startup_timer

`default_nettype wire
